// >>> logic/lc_status_pkg.sv
// Purpose: shared constants for the lifecycle status output block
// Assumes: 100 MHz clock, 32-bit register port
// Notes:   register offsets are byte addresses, one word each
package lc_status_pkg;
  // lifecycle state codes
  localparam logic [2:0] CHIP_MANUFACTURE_STATE   = 3'h0;
  localparam logic [2:0] DEVICE_MANUFACTURE_STATE = 3'h1;
  localparam logic [2:0] SECURE_ENABLED_STATE     = 3'h5;
  localparam logic [2:0] RETURNED_UNIT_STATE      = 3'h7;
  // test provisioning codes
  localparam logic [1:0] VIRGIN_MODE              = 2'h0;
  localparam logic [1:0] TESTER_INTERFACE_MODE    = 2'h1;
  localparam logic [1:0] PRODUCTION_MODE          = 2'h2;
  localparam logic [1:0] INVALID_MODE             = 2'h3;
  // widths
  localparam int         DBG_W                    = 128;
  localparam int         CFG_W                    = 16;
  localparam int         SEED_W                   = 64;
  // register offsets
  localparam logic [7:0] REG_STATE                = 8'h00;
  localparam logic [7:0] REG_MODE                 = 8'h04;
  localparam logic [7:0] REG_CTRL                 = 8'h08;
  localparam logic [7:0] REG_CFG                  = 8'h0c;
  localparam logic [7:0] REG_IRQ_STATUS           = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK             = 8'h14;
  localparam logic [7:0] REG_SEED_LO              = 8'h18;
  localparam logic [7:0] REG_SEED_HI              = 8'h1c;
  localparam logic [7:0] REG_DBG_EN0              = 8'h20;  // four words 0x20..0x2c
  localparam logic [7:0] REG_DBG_LOCK0            = 8'h30;  // four words 0x30..0x3c
  // ctrl bits
  localparam int         CTRL_PROV_BIT            = 0;
  localparam int         CTRL_QDENY_BIT           = 1;
  localparam int         CTRL_FATAL_BIT           = 2;
  // status bits
  localparam int         ST_FATAL_BIT             = 0;
  localparam int         ST_QACC_BIT              = 1;
  localparam int         ST_QDENY_BIT             = 2;
  localparam int         ST_SEED_BIT              = 3;
  localparam int         IRQ_W                    = 4;
endpackage

// >>> logic/pin_sync.sv
// Purpose: three-stage synchroniser for one pin with agreement check
// Assumes: pin is asynchronous to clk_i
// Notes:   a change counts when stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic pin_i,
  output logic      level_o
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       next_level;

  // shift chain; first stage only feeds second
  always_comb begin
    next_stage = {stage[1:0], pin_i};
    next_level = (stage[1] == stage[2]) ? stage[2] : level_o;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage   <= {3{RESET_VAL}};
      level_o <= RESET_VAL;
    end else begin
      stage   <= next_stage;
      level_o <= next_level;
    end
  end
endmodule

// >>> logic/lc_status_top.sv
// Purpose: lifecycle status outputs, seed capture and clock quiescence answer
// Assumes: single 100 MHz clock, registers over a plain strobe port
// Notes:   state and config arrive on input ports with valid strobes, errors as plain levels
//
// Behaviour
// RL1 - drive 3-bit lifecycle code, reset secure enabled
// RL2 - valid flag low at reset, high for valid
// RL3 - 128-bit debug enable mirrors register, zero reset
// RL4 - 128-bit debug lock mirrors register, zero reset
// RL5 - 16-bit config output equals register, zero reset
// RL6 - 2-bit provisioning mode, reset production code
// RL7 - provisioning reset request level while enabled
// RL8 - system performs warm reset on request
// RL9 - fatal flag on parity, integrity, internal error
// RL10 - outside ignores state while fatal asserted
// RL11 - route fatal flag to alarm logic
// RL12 - seed taken only while qualifier high
// RL13 - asynchronous active-low reset sets reset values
// RL14 - all logic on one clock
// RL15 - clock controller drives quiescence request
// RL16 - accept or deny request, both low reset
// RL17 - active output high while busy, high reset
// RL18 - scan mode, shift enable, gate override inputs
// RL19 - four-phase quiescence handshake ordering
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/10ps
module lc_status_top #(
  parameter int DBG_W = lc_status_pkg::DBG_W,
  parameter int CFG_W = lc_status_pkg::CFG_W
) (
  input  wire logic                             clk_i,
  input  wire logic                             rstn_i,
  input  wire logic [7:0]                       addr_i,
  input  wire logic [31:0]                      wdata_i,
  input  wire logic                             wr_i,
  input  wire logic                             rd_i,
  output logic      [31:0]                      rdata_o,
  output logic                                  irq_o,
  input  wire logic [2:0]                       state_load_i,
  input  wire logic                             state_load_valid_i,
  input  wire logic [CFG_W-1:0]                 otp_cfg_i,
  input  wire logic                             otp_cfg_valid_i,
  input  wire logic                             parity_err_i,
  input  wire logic                             otp_integrity_err_i,
  input  wire logic [lc_status_pkg::SEED_W-1:0] seed_i,
  input  wire logic                             seed_valid_i,
  input  wire logic                             qreqn_i,
  input  wire logic                             scan_mode_i,
  input  wire logic                             scan_shift_i,
  input  wire logic                             cg_override_i,
  output logic      [2:0]                       lifecycle_state_o,
  output logic                                  state_valid_flag_o,
  output logic      [DBG_W-1:0]                 debug_enable_o,
  output logic      [DBG_W-1:0]                 debug_lock_o,
  output logic      [CFG_W-1:0]                 persist_cfg_o,
  output logic      [1:0]                       test_provisioning_mode_o,
  output logic                                  provisioning_reset_request_o,
  output logic                                  fatal_err_o,
  output logic                                  qacceptn_o,
  output logic                                  qdeny_o,
  output logic                                  qactive_o
);
  localparam int NW = DBG_W / 32;
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic code_is_valid(input logic [2:0] c);
    code_is_valid = (c == lc_status_pkg::CHIP_MANUFACTURE_STATE) ||
                    (c == lc_status_pkg::DEVICE_MANUFACTURE_STATE) ||
                    (c == lc_status_pkg::SECURE_ENABLED_STATE) ||
                    (c == lc_status_pkg::RETURNED_UNIT_STATE);
  endfunction
  typedef enum logic [3:0] {
    Q_RUN    = 4'b0001,
    Q_ACCEPT = 4'b0010,
    Q_DENY   = 4'b0100,
    Q_IDLE   = 4'b1000
  } qstate_t;

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  logic [2:0]                       next_state_code;
  logic                             next_valid;
  logic [DBG_W-1:0]                 next_dbg_en;
  logic [DBG_W-1:0]                 next_dbg_lock;
  logic [CFG_W-1:0]                 next_cfg;
  logic [1:0]                       next_mode;
  logic [2:0]                       ctrl;
  logic [2:0]                       next_ctrl;
  logic                             next_fatal;
  logic [lc_status_pkg::SEED_W-1:0] seed;
  logic [lc_status_pkg::SEED_W-1:0] next_seed;
  logic [lc_status_pkg::IRQ_W-1:0]  irq_status;
  logic [lc_status_pkg::IRQ_W-1:0]  next_irq_status;
  logic [lc_status_pkg::IRQ_W-1:0]  irq_mask;
  logic [lc_status_pkg::IRQ_W-1:0]  next_irq_mask;
  logic [lc_status_pkg::IRQ_W-1:0]  events;
  logic [31:0]                      next_rdata;
  logic                             next_irq;
  qstate_t                          qstate;
  qstate_t                          next_qstate;
  logic                             next_qacceptn;
  logic                             next_qdeny;
  logic                             next_qactive;
  logic                             qreqn_s;
  logic                             wr_dbg_en;
  logic                             wr_dbg_lock;
  logic [1:0]                       word_sel;
  // quiescence request pin synchroniser
  pin_sync #(.RESET_VAL(1'b1)) u_qreq_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .pin_i   (qreqn_i),
    .level_o (qreqn_s)
  );
  // scan controls kept for hookup: all flops run ungated on clk_i
  logic scan_unused;
  assign scan_unused = scan_mode_i ^ scan_shift_i ^ cg_override_i; // RL18
  assign wr_dbg_en   = wr_i && (addr_i[7:4] == lc_status_pkg::REG_DBG_EN0[7:4]);
  assign wr_dbg_lock = wr_i && (addr_i[7:4] == lc_status_pkg::REG_DBG_LOCK0[7:4]);
  assign word_sel    = addr_i[3:2];

  // -------------------------------------------------------------
  // status outputs
  // -------------------------------------------------------------
  always_comb begin
    next_state_code = lifecycle_state_o;
    next_valid      = state_valid_flag_o;
    next_cfg        = persist_cfg_o;
    next_mode       = test_provisioning_mode_o;
    next_ctrl       = ctrl;
    next_seed       = seed;
    next_irq_mask   = irq_mask;
    if (state_load_valid_i) begin
      next_state_code = state_load_i;                            // RL1
      next_valid      = code_is_valid(state_load_i);             // RL2
    end
    if (otp_cfg_valid_i) begin
      next_cfg = otp_cfg_i;                                      // RL5
    end
    if (seed_valid_i) begin
      next_seed = seed_i;                                        // RL12
    end
    if (wr_i) begin
      case (addr_i)
        lc_status_pkg::REG_MODE:     next_mode     = wdata_i[1:0];  // RL6
        lc_status_pkg::REG_CTRL:     next_ctrl     = wdata_i[2:0];
        lc_status_pkg::REG_IRQ_MASK: next_irq_mask = wdata_i[lc_status_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    // fatal flag sticks until reset
    next_fatal = fatal_err_o | parity_err_i | otp_integrity_err_i |
                 ctrl[lc_status_pkg::CTRL_FATAL_BIT];               // RL9
  end

  // debug vectors, one word per register slot
  always_comb begin
    next_dbg_en   = debug_enable_o;
    next_dbg_lock = debug_lock_o;
    for (int w = 0; w < NW; w++) begin
      if (wr_dbg_en && (word_sel == w[1:0])) begin
        next_dbg_en[w*32 +: 32] = wdata_i;                       // RL3
      end
      if (wr_dbg_lock && (word_sel == w[1:0])) begin
        next_dbg_lock[w*32 +: 32] = wdata_i;                     // RL4
      end
    end
  end

  // all flops on the one clock, async low reset
  always_ff @(posedge clk_i or negedge rstn_i) begin             // RL14
    if (!rstn_i) begin                                           // RL13
      lifecycle_state_o            <= lc_status_pkg::SECURE_ENABLED_STATE;
      state_valid_flag_o           <= 1'b0;
      debug_enable_o               <= '0;
      debug_lock_o                 <= '0;
      persist_cfg_o                <= '0;
      test_provisioning_mode_o     <= lc_status_pkg::PRODUCTION_MODE;
      ctrl                         <= '0;
      provisioning_reset_request_o <= 1'b0;
      fatal_err_o                  <= 1'b0;
      seed                         <= '0;
      irq_mask                     <= '0;
    end else begin
      lifecycle_state_o            <= next_state_code;
      state_valid_flag_o           <= next_valid;
      debug_enable_o               <= next_dbg_en;
      debug_lock_o                 <= next_dbg_lock;
      persist_cfg_o                <= next_cfg;
      test_provisioning_mode_o     <= next_mode;
      ctrl                         <= next_ctrl;
      provisioning_reset_request_o <= next_ctrl[lc_status_pkg::CTRL_PROV_BIT]; // RL7
      fatal_err_o                  <= next_fatal;
      seed                         <= next_seed;
      irq_mask                     <= next_irq_mask;
    end
  end

  // -------------------------------------------------------------
  // quiescence handshake
  // -------------------------------------------------------------
  always_comb begin
    next_qstate = qstate;
    case (qstate)
      Q_RUN: begin
        if (!qreqn_s) begin
          next_qstate = ctrl[lc_status_pkg::CTRL_QDENY_BIT] ? Q_DENY : Q_ACCEPT; // RL16
        end
      end
      Q_ACCEPT: begin
        if (qreqn_s) begin
          next_qstate = Q_RUN;                                   // RL19
        end else begin
          next_qstate = Q_IDLE;
        end
      end
      Q_IDLE: begin
        if (qreqn_s) begin
          next_qstate = Q_RUN;                                   // RL19
        end
      end
      Q_DENY: begin
        if (qreqn_s) begin
          next_qstate = Q_RUN;                                   // RL19
        end
      end
      default: next_qstate = Q_RUN;
    endcase
    next_qacceptn = !((next_qstate == Q_ACCEPT) || (next_qstate == Q_IDLE));
    next_qdeny    = (next_qstate == Q_DENY);
    // active unless quiesced with nothing pending
    next_qactive  = !(next_qstate == Q_IDLE) || wr_i || rd_i; // RL17
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      qstate     <= Q_RUN;
      qacceptn_o <= 1'b0;                                        // RL16
      qdeny_o    <= 1'b0;
      qactive_o  <= 1'b1;                                        // RL17
    end else begin
      qstate     <= next_qstate;
      qacceptn_o <= next_qacceptn;
      qdeny_o    <= next_qdeny;
      qactive_o  <= next_qactive;
    end
  end

  // -------------------------------------------------------------
  // interrupts and read port
  // -------------------------------------------------------------
  always_comb begin
    events = '0;
    events[lc_status_pkg::ST_FATAL_BIT] = next_fatal & ~fatal_err_o;
    events[lc_status_pkg::ST_QACC_BIT]  = (next_qstate == Q_ACCEPT) && (qstate == Q_RUN);
    events[lc_status_pkg::ST_QDENY_BIT] = (next_qstate == Q_DENY) && (qstate == Q_RUN);
    events[lc_status_pkg::ST_SEED_BIT]  = seed_valid_i;
    next_rdata = '0;
    if (rd_i) begin
      case (addr_i)
        lc_status_pkg::REG_STATE:      next_rdata = {28'h0000000, state_valid_flag_o,
                                                     lifecycle_state_o};
        lc_status_pkg::REG_MODE:       next_rdata = {30'h00000000, test_provisioning_mode_o};
        lc_status_pkg::REG_CTRL:       next_rdata = {28'h0000000, fatal_err_o, ctrl};
        lc_status_pkg::REG_CFG:        next_rdata = {{(32-CFG_W){1'b0}}, persist_cfg_o};
        lc_status_pkg::REG_IRQ_STATUS: next_rdata = {28'h0000000, irq_status};
        lc_status_pkg::REG_IRQ_MASK:   next_rdata = {28'h0000000, irq_mask};
        lc_status_pkg::REG_SEED_LO:    next_rdata = seed[31:0];
        lc_status_pkg::REG_SEED_HI:    next_rdata = seed[63:32];
        default: begin
          if (addr_i[7:4] == lc_status_pkg::REG_DBG_EN0[7:4]) begin
            next_rdata = debug_enable_o[word_sel*32 +: 32];
          end else if (addr_i[7:4] == lc_status_pkg::REG_DBG_LOCK0[7:4]) begin
            next_rdata = debug_lock_o[word_sel*32 +: 32];
          end
        end
      endcase
    end
    // read clears, a new event in the same cycle wins
    next_irq_status = irq_status;
    if (rd_i && (addr_i == lc_status_pkg::REG_IRQ_STATUS)) begin
      next_irq_status = '0;
    end
    next_irq_status = next_irq_status | events;
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_status <= '0;
      rdata_o    <= '0;
      irq_o      <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      rdata_o    <= next_rdata;
      irq_o      <= next_irq;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  AST_VALID_CODE: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL2
    state_valid_flag_o |-> code_is_valid(lifecycle_state_o))
    else $error("valid flag with reserved code");
  AST_STATE_LOAD: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL1
    state_load_valid_i |=> lifecycle_state_o == $past(state_load_i))
    else $error("state code not loaded");
  AST_CFG_LOAD: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL5
    otp_cfg_valid_i |=> persist_cfg_o == $past(otp_cfg_i))
    else $error("config not loaded");
  AST_DBG_STABLE: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL3
    !wr_i |=> $stable(debug_enable_o) && $stable(debug_lock_o))
    else $error("debug vectors changed without write");
  AST_SEED_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL12
    !seed_valid_i |=> $stable(seed))
    else $error("seed taken without qualifier");
  AST_FATAL_SET: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL9
    (parity_err_i || otp_integrity_err_i) |=> fatal_err_o [*2])
    else $error("fatal flag not raised and held");
  AST_PROV_LEVEL: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL7
    (wr_i && (addr_i == lc_status_pkg::REG_CTRL)) |=> provisioning_reset_request_o ==
      $past(wdata_i[lc_status_pkg::CTRL_PROV_BIT]))
    else $error("provisioning request differs from enable");
  AST_Q_EXCL: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL16
    !(!qacceptn_o && qdeny_o))
    else $error("accept and deny together");
  AST_Q_RELEASE: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL19
    ($rose(qacceptn_o) || $fell(qdeny_o)) |-> qreqn_s)
    else $error("response dropped before request rose");
  AST_Q_ACTIVE: assert property (@(posedge clk_i) disable iff (!rstn_i) // RL17
    (qacceptn_o && !qdeny_o) |-> qactive_o)
    else $error("inactive while not quiesced");
  COV_ACCEPT: cover property (@(posedge clk_i) disable iff (!rstn_i) $fell(qacceptn_o));
  COV_DENY:   cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(qdeny_o));
  COV_FATAL:  cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(fatal_err_o));
  COV_IRQ:    cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(irq_o));
endmodule

// >>> bench/qchan_ctrl_model.sv
// Purpose: clock controller model that drives the quiescence request
// Assumes: answers are registered on clk_i
// Notes:   a go_i pulse runs one four-phase exchange, seen_o = {deny, accept}
`timescale 1ns/10ps
module qchan_ctrl_model (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic       qacceptn_i,
  input  wire logic       qdeny_i,
  output logic            qreqn_o,
  output logic            done_o,
  output logic      [1:0] seen_o
);
  int n;
  // lower request, wait for an answer, release, wait for accept high and deny low
  initial begin
    qreqn_o = 1'b1;
    done_o  = 1'b0;
    seen_o  = 2'h0;
    forever begin
      @(posedge clk_i);
      if (go_i === 1'b1) begin
        done_o  <= 1'b0;
        qreqn_o <= 1'b0;
        n = 0;
        do begin
          @(posedge clk_i);
          n++;
        end while (qacceptn_i !== 1'b0 && qdeny_i !== 1'b1 && n < 60);
        seen_o  <= {qdeny_i === 1'b1, qacceptn_i === 1'b0};
        qreqn_o <= 1'b1;
        n = 0;
        do begin
          @(posedge clk_i);
          n++;
        end while ((qacceptn_i !== 1'b1 || qdeny_i !== 1'b0) && n < 60);
        done_o <= 1'b1;
      end
    end
  end
endmodule

// >>> bench/lc_status_top_tb.sv
// Purpose: self-checking bench for the lifecycle status outputs
// Assumes: 100 MHz clock, plain strobe register port
// Notes:   scan controls are tied low, they have no functional effect
`timescale 1ns/10ps
module lc_status_top_tb;
  logic        clk_i, rstn_i, wr_i, rd_i, irq_o, sv, cv, dv, perr, ierr, go, done;
  logic        valid_flag, prov, fatal, qacc_n, qdeny, qact, ev;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, rdata_o, d;
  logic [2:0]  st, lcs;
  logic [15:0] cfg, pcfg;
  logic [63:0] seed;
  logic [1:0]  mode, seen;
  logic        qreqn;
  logic [127:0] den, dlk, exp_en, exp_lk;
  int          miscompares, total_checks, n;

  // ----------------------------------------
  // clock, partner, design
  // ----------------------------------------
  always #5 clk_i = ~clk_i;
  qchan_ctrl_model ctrl (.clk_i(clk_i), .go_i(go), .qacceptn_i(qacc_n), .qdeny_i(qdeny),
    .qreqn_o(qreqn), .done_o(done), .seen_o(seen));
  lc_status_top uut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .state_load_i(st),
    .state_load_valid_i(sv), .otp_cfg_i(cfg), .otp_cfg_valid_i(cv), .parity_err_i(perr),
    .otp_integrity_err_i(ierr), .seed_i(seed), .seed_valid_i(dv), .qreqn_i(qreqn),
    .scan_mode_i(1'b0), .scan_shift_i(1'b0), .cg_override_i(1'b0),
    .lifecycle_state_o(lcs), .state_valid_flag_o(valid_flag), .debug_enable_o(den),
    .debug_lock_o(dlk), .persist_cfg_o(pcfg), .test_provisioning_mode_o(mode),
    .provisioning_reset_request_o(prov), .fatal_err_o(fatal), .qacceptn_o(qacc_n),
    .qdeny_o(qdeny), .qactive_o(qact));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic report_and_stop();
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic settle();
    @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask
  task automatic push(input logic [2:0] s, input logic [2:0] vs, input logic [15:0] c,
                      input logic [63:0] sd, input logic [1:0] er);
    @(posedge clk_i);
    {st, cfg, seed} <= {s, c, sd};
    {sv, cv, dv}    <= vs;
    {perr, ierr}    <= er;
    @(posedge clk_i);
    {sv, cv, dv, perr, ierr} <= 5'h0;
    settle();
  endtask
  task automatic do_reset();
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    chk({lcs, valid_flag}, {lc_status_pkg::SECURE_ENABLED_STATE, 1'b0});
    chk({den, dlk, pcfg}, '0);
    chk(mode, lc_status_pkg::PRODUCTION_MODE);
    chk({prov, fatal, irq_o, rdata_o}, '0);
    chk({qacc_n, qdeny, qact}, 3'h1);
    @(posedge clk_i);
    rstn_i <= 1'b1;
  endtask
  task automatic qreq(input logic [1:0] e);
    @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    n = 0;
    do begin
      settle();
      n++;
    end while (done !== 1'b1 && n < 300);
    chk({done, seen}, {1'b1, e});
    chk({qacc_n, qdeny, qact}, 3'h5);
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #100us;
    miscompares++;
    report_and_stop();
  end
  initial begin
    {clk_i, rstn_i, wr_i, rd_i, go, sv, cv, dv, perr, ierr} = '0;
    {addr_i, wdata_i, st, cfg, seed, miscompares, total_checks} = '0;
    do_reset();
    rdchk(8'hfc, 32'h0);
    for (int i = 0; i < 8; i++) begin
      push(i[2:0], 3'h4, 16'h0, 64'h0, 2'h0);
      ev = (i == 0) || (i == 1) || (i == 5) || (i == 7);
      chk({lcs, valid_flag}, {i[2:0], ev});
      rdchk(lc_status_pkg::REG_STATE, {28'h0, ev, i[2:0]});
    end
    push(3'h0, 3'h3, 16'ha5c3, 64'h0, 2'h0);
    chk({lcs, pcfg}, {3'h7, 16'ha5c3});
    push(3'h0, 3'h1, 16'h1234, 64'h0123456789abcdef, 2'h0);
    push(3'h0, 3'h0, 16'h0, 64'hfedcba9876543210, 2'h0);
    chk(pcfg, 16'ha5c3);
    rdchk(lc_status_pkg::REG_CFG, 32'ha5c3);
    rdchk(lc_status_pkg::REG_SEED_LO, 32'h89abcdef);
    rdchk(lc_status_pkg::REG_SEED_HI, 32'h01234567);
    chk(irq_o, 1'b0);
    wr(lc_status_pkg::REG_IRQ_MASK, 32'h8);
    settle();
    chk(irq_o, 1'b1);
    rdchk(lc_status_pkg::REG_IRQ_STATUS, 32'h8);
    settle();
    chk(irq_o, 1'b0);
    for (int k = 0; k < 4; k++) begin
      d = 32'h01020304 + 32'h10101010 * k;
      exp_en[32*k +: 32] = d;
      exp_lk[32*k +: 32] = ~d;
      wr(lc_status_pkg::REG_DBG_EN0 + 8'(4 * k), d);
      wr(lc_status_pkg::REG_DBG_LOCK0 + 8'(4 * k), ~d);
    end
    settle();
    chk({den, dlk}, {exp_en, exp_lk});
    rdchk(lc_status_pkg::REG_DBG_EN0 + 8'h8, 32'h21222324);
    for (int m = 0; m < 4; m++) begin
      wr(lc_status_pkg::REG_MODE, 32'(m));
      settle();
      chk(mode, m[1:0]);
    end
    wr(lc_status_pkg::REG_CTRL, 32'h1);
    repeat (4) settle();
    chk(prov, 1'b1);
    wr(lc_status_pkg::REG_CTRL, 32'h0);
    settle();
    chk(prov, 1'b0);
    qreq(2'h1);
    wr(lc_status_pkg::REG_CTRL, 32'h2);
    qreq(2'h2);
    push(3'h0, 3'h0, 16'h0, 64'h0, 2'h2);
    repeat (3) settle();
    chk(fatal, 1'b1);
    rdchk(lc_status_pkg::REG_CTRL, 32'ha);
    rdchk(lc_status_pkg::REG_IRQ_STATUS, 32'h7);
    do_reset();
    push(3'h0, 3'h0, 16'h0, 64'h0, 2'h1);
    chk(fatal, 1'b1);
    report_and_stop();
  end
endmodule
